// >>> rtl/sli_pkg.sv
package sli_pkg;

    // ==========================================================
    // clock and blink timing
    // ==========================================================
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned FAST_BLINK_HZ = 5;
    localparam int unsigned SLOW_BLINK_HZ = 1;
    // half period counts: lamp toggles twice per blink period
    localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_BLINK_HZ);
    localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_BLINK_HZ);
    // link activity stretch so single host packets stay visible (ms)
    localparam int unsigned ACT_HOLD_MS   = 20;
    localparam int unsigned ACT_HOLD_CYC  = (CLK_HZ / 1000) * ACT_HOLD_MS;
    localparam int unsigned CNT_W         = 24;

    // ==========================================================
    // apb register map
    // ==========================================================
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MK = 8'h0C;

    // ctrl bit positions
    localparam int unsigned CTRL_LAMP_EN = 0;
    localparam int unsigned CTRL_W       = 1;
    localparam logic [CTRL_W-1:0] CTRL_RST = 1'h1;

    // event bit positions (irq status and mask)
    localparam int unsigned EV_FAULT  = 0;
    localparam int unsigned EV_UPD    = 1;
    localparam int unsigned EV_SYNC   = 2;
    localparam int unsigned EV_LINKDN = 3;
    localparam int unsigned EV_W      = 4;

    // ==========================================================
    // power lamp modes
    // ==========================================================
    typedef enum logic [1:0] {
        SLI_PWR_STEADY,
        SLI_PWR_FAST,
        SLI_PWR_SLOW
    } sli_pwr_e;

    typedef struct packed {
        logic healthy;
        logic fault;
        logic update;
        logic link;
        logic sync_lost;
    } sli_cond_s;

endpackage

// >>> rtl/sli_status_led.sv
`timescale 1ns/1ns
module sli_status_led #(
    parameter int unsigned FAST_HALF = sli_pkg::FAST_HALF_CYC,
    parameter int unsigned SLOW_HALF = sli_pkg::SLOW_HALF_CYC,
    parameter int unsigned ACT_HOLD  = sli_pkg::ACT_HOLD_CYC
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              healthy,
    input  wire logic              fw_fault,
    input  wire logic              fw_update,
    input  wire logic              link_active,
    input  wire logic              host_traffic,
    input  wire logic              sync_lost,
    output logic                   pwr_lamp,
    output logic                   link_lamp,
    output logic                   irq
);

    // ==========================================================
    // condition synchronisers
    // ==========================================================
    sli_pkg::sli_cond_s cond_meta_q;
    sli_pkg::sli_cond_s cond_q;
    logic               traf_meta_q;
    logic               traf_q;
    logic               traf_d1_q;
    wire  sli_pkg::sli_cond_s cond_raw = '{healthy, fw_fault, fw_update, link_active, sync_lost};

    // status lines come from other logic blocks, treat as asynchronous
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_meta_q <= '0;
            cond_q      <= '0;
            traf_meta_q <= 1'b0;
            traf_q      <= 1'b0;
            traf_d1_q   <= 1'b0;
        end else if (clk_en) begin
            cond_meta_q <= cond_raw;
            cond_q      <= cond_meta_q;
            traf_meta_q <= host_traffic;
            traf_q      <= traf_meta_q;
            traf_d1_q   <= traf_q;
        end
    end

    wire traf_edge = traf_q ^ traf_d1_q; // any toggle counts as a packet

    // ==========================================================
    // blink timebases
    // ==========================================================
    logic [sli_pkg::CNT_W-1:0] fast_cnt_q;
    logic [sli_pkg::CNT_W-1:0] slow_cnt_q;
    logic                      fast_ph_q;
    logic                      slow_ph_q;
    wire  fast_wrap = (fast_cnt_q == sli_pkg::CNT_W'(FAST_HALF - 1));
    wire  slow_wrap = (slow_cnt_q == sli_pkg::CNT_W'(SLOW_HALF - 1));

    // free running so both lamps blink in phase with each other
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_cnt_q <= '0;
            slow_cnt_q <= '0;
            fast_ph_q  <= 1'b1;
            slow_ph_q  <= 1'b1;
        end else if (clk_en) begin
            fast_cnt_q <= fast_wrap ? '0 : fast_cnt_q + 1'b1;
            slow_cnt_q <= slow_wrap ? '0 : slow_cnt_q + 1'b1;
            if (fast_wrap) fast_ph_q <= ~fast_ph_q;
            if (slow_wrap) slow_ph_q <= ~slow_ph_q;
        end
    end

    // ==========================================================
    // power lamp mode
    // ==========================================================
    sli_pkg::sli_pwr_e pwr_mode;
    // fault outranks update: an aborted update must show as an error
    assign pwr_mode = cond_q.fault  ? sli_pkg::SLI_PWR_FAST :
                      cond_q.update ? sli_pkg::SLI_PWR_SLOW :
                                      sli_pkg::SLI_PWR_STEADY;

    logic pwr_d;
    always_comb begin
        case (pwr_mode)
            sli_pkg::SLI_PWR_STEADY: pwr_d = cond_q.healthy;
            sli_pkg::SLI_PWR_FAST:   pwr_d = fast_ph_q;
            sli_pkg::SLI_PWR_SLOW:   pwr_d = slow_ph_q;
            default:                 pwr_d = 1'b0;
        endcase
    end

    // ==========================================================
    // link lamp
    // ==========================================================
    logic [sli_pkg::CNT_W-1:0] act_cnt_q;
    wire  act_busy = (act_cnt_q != '0);

    // stretch each packet: sparse traffic flickers, dense looks steady
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_cnt_q <= '0;
        end else if (clk_en) begin
            if (traf_edge)
                act_cnt_q <= sli_pkg::CNT_W'(ACT_HOLD);
            else if (act_busy)
                act_cnt_q <= act_cnt_q - 1'b1;
        end
    end

    logic link_d;
    always_comb begin
        if (cond_q.sync_lost) begin
            link_d = slow_ph_q;
        end else if (cond_q.link) begin
            link_d = act_busy || (ACT_HOLD == 0) ? 1'b1 : 1'b0;
        end else begin
            link_d = 1'b0;
        end
    end

    // ==========================================================
    // apb slave and interrupt bits
    // ==========================================================
    logic [sli_pkg::CTRL_W-1:0] ctrl_q;
    logic [sli_pkg::EV_W-1:0]   ist_q;
    logic [sli_pkg::EV_W-1:0]   imk_q;
    sli_pkg::sli_cond_s         cond_d1_q;

    wire acc      = psel && penable;
    wire wr       = acc && pwrite;
    wire hit_ctrl = (paddr == sli_pkg::ADDR_CTRL);
    wire hit_stat = (paddr == sli_pkg::ADDR_STATUS);
    wire hit_ist  = (paddr == sli_pkg::ADDR_IRQ_ST);
    wire hit_imk  = (paddr == sli_pkg::ADDR_IRQ_MK);
    wire hit_any  = hit_ctrl | hit_stat | hit_ist | hit_imk;
    wire lamp_en  = ctrl_q[sli_pkg::CTRL_LAMP_EN];

    // rising edges of conditions, plus link drop
    wire [sli_pkg::EV_W-1:0] ev_set = {
        cond_d1_q.link & ~cond_q.link,
        cond_q.sync_lost & ~cond_d1_q.sync_lost,
        cond_q.update & ~cond_d1_q.update,
        cond_q.fault & ~cond_d1_q.fault};
    wire [sli_pkg::EV_W-1:0] ist_clr = (wr && hit_ist) ? pwdata[sli_pkg::EV_W-1:0] : '0;

    wire [31:0] rd_mux =
        hit_ctrl ? 32'(ctrl_q) :
        hit_stat ? {25'h0, pwr_mode == sli_pkg::SLI_PWR_SLOW, cond_q.sync_lost,
                    cond_q.link, cond_q.update, cond_q.fault, link_lamp, pwr_lamp} :
        hit_ist  ? 32'(ist_q) :
        hit_imk  ? 32'(imk_q) : 32'h0000_0000;

    // no wait state: ready rises for the access phase; prdata registered so outputs come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel && !pready;
            pslverr <= psel && !pready && !hit_any;
            prdata  <= rd_mux;
        end
    end

    // registers take writes only at the completing access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= sli_pkg::CTRL_RST;
            imk_q     <= '0;
            ist_q     <= '0;
            cond_d1_q <= '0;
        end else if (clk_en) begin
            cond_d1_q <= cond_q;
            if (wr && pready && hit_ctrl) ctrl_q <= pwdata[sli_pkg::CTRL_W-1:0];
            if (wr && pready && hit_imk)  imk_q  <= pwdata[sli_pkg::EV_W-1:0];
            // set wins over write-one-to-clear
            ist_q <= (ist_q & ~(pready ? ist_clr : '0)) | ev_set;
        end
    end

    // lamps and interrupt leave straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_lamp  <= 1'b0;
            link_lamp <= 1'b0;
            irq       <= 1'b0;
        end else if (clk_en) begin
            pwr_lamp  <= pwr_d && lamp_en;
            link_lamp <= link_d && lamp_en;
            irq       <= |(ist_q & imk_q);
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    steady_pwr_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && lamp_en && pwr_mode == sli_pkg::SLI_PWR_STEADY && cond_q.healthy
        ##1 clk_en |-> pwr_lamp)
        else $error("power lamp not steady in normal run");

    fault_blink_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && lamp_en && cond_q.fault && fast_wrap ##1 clk_en && cond_q.fault
        |-> ##1 pwr_lamp != $past(pwr_lamp))
        else $error("fault blink did not toggle at fast wrap");

    update_blink_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && lamp_en && pwr_mode == sli_pkg::SLI_PWR_SLOW |=> !clk_en || pwr_lamp == $past(slow_ph_q))
        else $error("update blink does not follow slow phase");

    link_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && lamp_en && cond_q.link && !cond_q.sync_lost && act_busy |=> !clk_en || link_lamp)
        else $error("link lamp dark during active traffic");

    sync_blink_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && lamp_en && cond_q.sync_lost |=> !clk_en || link_lamp == $past(slow_ph_q))
        else $error("sync loss blink wrong");

    link_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !cond_q.link && !cond_q.sync_lost |=> !clk_en || !link_lamp)
        else $error("link lamp lit with no link");

    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && |(ist_q & imk_q) |=> !clk_en || irq)
        else $error("unmasked event did not raise irq");

    // the level must also fall once the cause is cleared or masked
    irq_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !(|(ist_q & imk_q)) |=> !irq)
        else $error("irq high with no unmasked event");

    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && !pready ##1 clk_en |-> pready)
        else $error("apb slave missed its wait state");

    // ==========================================================
    // link, event, blanking, freeze and bus checks
    // ==========================================================
    // a host packet on a live link lights the lamp two edges on
    traffic_lamp_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && lamp_en && cond_q.link && !cond_q.sync_lost && traf_edge
        ##1 clk_en && lamp_en && cond_q.link && !cond_q.sync_lost |-> ##1 link_lamp)
        else $error("host packet did not light link lamp");

    // once the stretch runs out the lamp goes dark until the next packet
    traffic_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && lamp_en && cond_q.link && !cond_q.sync_lost && !act_busy && ACT_HOLD != 0
        |=> !link_lamp)
        else $error("link lamp lit with no recent traffic");

    // start of an update leaves its sticky event bit behind
    upd_event_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && cond_q.update && !cond_d1_q.update |=> ist_q[sli_pkg::EV_UPD])
        else $error("update start not recorded");

    // an event in the same cycle as its clear must survive
    set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && (|ev_set) |=> (ist_q & $past(ev_set)) == $past(ev_set))
        else $error("event lost against clear");

    // writing the enable low blanks both lamps
    lamp_blank_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !lamp_en |=> !pwr_lamp && !link_lamp)
        else $error("lamp lit while blanked");

    // a low enable must freeze the outputs, not just the counters
    freeze_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(pwr_lamp) && $stable(link_lamp) && $stable(irq) && $stable(pready))
        else $error("outputs moved with clock enable low");

    // ready stands one cycle, so a held select completes at most every other cycle
    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && pready |=> !pready)
        else $error("apb ready held too long");

    // unmapped offsets answer with an error on the ready cycle
    bad_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && !pready && !hit_any |=> pready && pslverr)
        else $error("unmapped access not flagged");

endmodule

// >>> sim/sli_host_model.sv
`timescale 1ns/1ns
// ==========================================================
// host side stand-in: connection, packets, sync, firmware push
// ==========================================================
module sli_host_model #(
    parameter int unsigned GAP = 3
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic want_link,
    input  wire logic want_traffic,
    input  wire logic want_desync,
    input  wire logic want_upgrade,
    output logic      link_active,
    output logic      host_traffic,
    output logic      sync_lost,
    output logic      fw_update
);
    logic [3:0] gap_q;

    // packet pacing
    // one toggle per packet; a larger gap plays a slow host
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q        <= 4'h0;
            host_traffic <= 1'b0;
        end else if (want_link && want_traffic) begin
            gap_q        <= (gap_q == 4'(GAP - 1)) ? 4'h0 : gap_q + 4'h1;
            host_traffic <= (gap_q == 4'(GAP - 1)) ? ~host_traffic : host_traffic;
        end
    end

    // link state
    // update simply follows want_upgrade, registered one clock later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_active <= 1'b0;
            sync_lost   <= 1'b0;
            fw_update   <= 1'b0;
        end else begin
            link_active <= want_link;
            sync_lost   <= want_desync;
            fw_update   <= want_upgrade;
        end
    end
endmodule

// >>> sim/sli_status_led_tb_top.sv
`timescale 1ns/1ns
module sli_status_led_tb_top;
    // ==========================================================
    // nets
    // ==========================================================
    logic        pclk, presetn, psel, penable, pwrite, healthy, fw_fault, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, pwr_lamp, link_lamp, irq;
    logic        link_active, host_traffic, sync_lost, fw_update;
    logic        want_link, want_traffic, want_desync, want_upgrade;
    int          bad_count, tests_run;
    logic        clk_en;

    // short counts keep blink periods a few cycles long
    sli_status_led #(.FAST_HALF(4), .SLOW_HALF(10), .ACT_HOLD(6)) uut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .healthy(healthy), .fw_fault(fw_fault), .fw_update(fw_update),
        .link_active(link_active), .host_traffic(host_traffic), .sync_lost(sync_lost),
        .pwr_lamp(pwr_lamp), .link_lamp(link_lamp), .irq(irq));

    sli_host_model #(.GAP(3)) host (
        .pclk(pclk), .presetn(presetn), .want_link(want_link), .want_traffic(want_traffic),
        .want_desync(want_desync), .want_upgrade(want_upgrade), .link_active(link_active),
        .host_traffic(host_traffic), .sync_lost(sync_lost), .fw_update(fw_update));

    // ==========================================================
    // helpers
    // ==========================================================
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // one apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            conclude();
        end
    endtask

    function automatic logic lamp(input bit s);
        return s ? link_lamp : pwr_lamp;
    endfunction

    // lets the two-flop input sync and lamp register catch up
    task automatic settle();
        repeat (8) @(negedge pclk);
    endtask

    task automatic hold(input bit s, input logic v, input int c);
        repeat (c) begin
            @(negedge pclk);
            chk({31'h0, lamp(s)}, {31'h0, v});
        end
    endtask

    // first run is skipped since the free counter starts mid-phase
    task automatic interval(input bit s, input int e);
        int n;
        logic v;
        repeat (2) begin
            v = lamp(s);
            n = 0;
            while (lamp(s) === v && n < 100) begin
                @(negedge pclk);
                n++;
            end
        end
        if (n >= 100) begin
            bad_count++;
            conclude();
        end
        chk(32'(n), 32'(e));
    endtask

    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_regs();
        apb(1'b0, sli_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, sli_pkg::ADDR_CTRL, 32'h0);
        settle();
        hold(1'b0, 1'b0, 4);
        apb(1'b1, sli_pkg::ADDR_CTRL, 32'h1);
        settle();
        hold(1'b0, 1'b1, 20);
        @(posedge pclk);
        healthy <= 1'b0;
        settle();
        hold(1'b0, 1'b0, 4);
        @(posedge pclk);
        healthy <= 1'b1;
        $display("done regs and steady");
    endtask

    task automatic t_fault();
        @(posedge pclk);
        fw_fault <= 1'b1;
        settle();
        interval(1'b0, 4);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, sli_pkg::ADDR_IRQ_ST, 32'h0);
        chk(rd & 32'h1, 32'h1);
        apb(1'b0, sli_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'h4, 32'h4);
        apb(1'b1, sli_pkg::ADDR_IRQ_MK, 32'hF);
        repeat (3) @(negedge pclk);
        chk({31'h0, irq}, 32'h1);
        @(posedge pclk);
        fw_fault <= 1'b0;
        apb(1'b1, sli_pkg::ADDR_IRQ_ST, 32'hF);
        repeat (3) @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        settle();
        hold(1'b0, 1'b1, 10);
        $display("done fault");
    endtask

    task automatic t_update();
        @(posedge pclk);
        want_upgrade <= 1'b1;
        settle();
        interval(1'b0, 10);
        // enable low must hold the blink longer than a half period
        @(posedge pclk);
        clk_en <= 1'b0;
        @(negedge pclk);
        hold(1'b0, pwr_lamp, 12);
        @(posedge pclk);
        clk_en <= 1'b1;
        @(posedge pclk);
        want_upgrade <= 1'b0;
        settle();
        hold(1'b0, 1'b1, 20);
        $display("done update");
    endtask

    task automatic t_link();
        @(posedge pclk);
        want_link <= 1'b1;
        want_traffic <= 1'b1;
        settle();
        hold(1'b1, 1'b1, 20);
        @(posedge pclk);
        want_traffic <= 1'b0;
        repeat (16) @(negedge pclk);
        hold(1'b1, 1'b0, 5);
        @(posedge pclk);
        want_link <= 1'b0;
        settle();
        hold(1'b1, 1'b0, 10);
        @(posedge pclk);
        want_desync <= 1'b1;
        settle();
        interval(1'b1, 10);
        @(posedge pclk);
        want_desync <= 1'b0;
        settle();
        hold(1'b1, 1'b0, 5);
        $display("done link");
    endtask

    // ==========================================================
    // clock and main sequence
    // ==========================================================
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; healthy = 1'b1; fw_fault = 1'b0; want_link = 1'b0;
        want_traffic = 1'b0; want_desync = 1'b0; want_upgrade = 1'b0;
        bad_count = 0; tests_run = 0;
        clk_en = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_fault();
        t_update();
        t_link();
        conclude();
    end
endmodule
